// *** verilog/ssu_regs.svh ***
// Purpose: Named constants for the serial shift unit.
// Assumes: Included by bare name from the design files.
// Notes: Holds definitions only.
`ifndef SSU_REGS_SVH
`define SSU_REGS_SVH
`define SSU_DATA_W        8
`define SSU_CNT_W         4
`define SSU_SHIFT_RST     8'h00
`define SSU_CNT_RST       4'h0
`define SSU_BIT_RST       1'b0
`define SSU_OUT_RST       1'b1
`define SSU_SYNC_STAGES   2
`define SSU_CLK_NS        10
`define SSU_DIV_MASTER3   2
`define SSU_DIV_SLAVE3    4
`define SSU_DIV_TWO       16
`endif

// *** verilog/ssu_pkg.sv ***
// Purpose: Types shared by the serial shift unit files.
// Assumes: Nothing is imported; users write ssu_pkg::name.
// Notes: Wire modes select the output pin and two-wire behaviour.
package ssu_pkg;
   typedef enum logic [1:0] {
      SSU_WM_OFF      = 2'b00,
      SSU_WM_THREE    = 2'b01,
      SSU_WM_TWO      = 2'b10,
      SSU_WM_TWO_HOLD = 2'b11
   } ssu_wire_e;
endpackage

// *** verilog/ssu_sync.sv ***
// Purpose: Multi-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: Only the last stage is visible outside.
`timescale 1ns/1ps
`include "ssu_regs.svh"
module ssu_sync #(
   parameter int WIDTH  = 1,
   parameter int STAGES = `SSU_SYNC_STAGES
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage_q [STAGES];

   initial begin
      if (STAGES < 2 || WIDTH < 1) begin
         $error("ssu_sync needs at least two stages and one bit");
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_q[i] <= '0;
         end
      end else begin
         stage_q[0] <= asyncIn;
         for (int i = 1; i < STAGES; i++) begin
            stage_q[i] <= stage_q[i-1];
         end
      end
   end

   assign syncOut = stage_q[STAGES-1];
endmodule

// *** verilog/ssu_core.sv ***
// Purpose: Serial shift unit with shift register, edge counter and clock select.
// Assumes: Control bits and strobes come from same-clock logic; pins are async.
// Notes: Strobes are one-cycle pulses; the serial clock pin is oversampled.
`timescale 1ns/1ps
`include "ssu_regs.svh"

// Function
// R01: Unbuffered shift register, read and written directly by software.
// R02: Shift register MSB goes to data-out or two-wire data pin by wire mode.
// R03: Output latch moves output changes to the edge opposite sampling.
// R04: Serial input always comes from the serial data input pin.
// R05: Four-bit readable, writable counter raising an overflow event.
// R06: Shift register and counter step from the same selected source.
// R07: External clock makes the counter step on both serial clock edges.
// R08: Clock sources are clock pin, timer-zero overflow or software strobe.
// R09: Two-wire start condition sets a flag that can request an interrupt.
// R10: Two-wire mode holds clock low after start or after overflow.
// R11: Three-wire mode gives SPI modes 0 and 1, no slave select.
// R12: Cross-connected master and slave swap bytes after eight clocks.
// R13: Master clock comes from port toggling or the pin toggle strobe.
// R14: Edge select 0 samples on rising, changes output on falling edge.
// R15: Edge select 1 samples on falling, changes output on rising edge.
// R16: Both ends load data and enable drivers half a clock before sampling.
// R17: Software clears the counter before a transfer starts.
// R18: Sixteen counted edges overflow the counter and set the overflow flag.
// R19: The overflow request also wakes the processor from idle sleep.
// R20: Serial clock at most system/2 master, /4 slave, /16 two-wire.
// R21: Pin toggle strobe steps counter; with clock strobe it also shifts. Here: counts only with external source and clock strobe; never shifts.
// R22: A software write to the shift register beats a same-cycle shift.
// R23: Latch transparent in first half with external clock, always otherwise.
// R24: The serial clock pin is synchronised and its edges detected.
module ssu_core #(
   parameter int DATA_W = `SSU_DATA_W,
   parameter int CNT_W  = `SSU_CNT_W
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              dataWrite,
   input  wire logic [DATA_W-1:0] dataWrData,
   output logic      [DATA_W-1:0] dataRd,
   input  wire logic              cntWrite,
   input  wire logic [CNT_W-1:0]  cntWrData,
   output logic      [CNT_W-1:0]  cntRd,
   input  wire logic              ovfFlagClear,
   input  wire logic              startFlagClear,
   input  wire logic              ovfIrqEnable,
   input  wire logic              startIrqEnable,
   input  wire logic              cpuIdle,
   input  wire logic [1:0]        wireMode,
   input  wire logic              clockSourceSelect,
   input  wire logic              externalEdgeSelect,
   input  wire logic              softwareClockStrobe,
   input  wire logic              clockPinToggleStrobe,
   input  wire logic              timerZeroOvf,
   input  wire logic              serialDataIn,
   input  wire logic              serialClockIn,
   output logic                   serialDataOut,
   output logic                   sdaOutEn,
   output logic                   sclOutEn,
   output logic                   clockPinOut,
   output logic                   counterOverflowFlag,
   output logic                   startFlag,
   output logic                   ovfIrq,
   output logic                   startIrq,
   output logic                   idleWake
);
   localparam logic [CNT_W-1:0] CNT_TOP = {CNT_W{1'b1}};

   initial begin
      if (DATA_W < 2 || CNT_W < 1) begin
         $error("ssu_core needs DATA_W >= 2 and CNT_W >= 1");
      end
   end

   function automatic logic edgeSeen(input logic prev, input logic cur, input logic rise);
      edgeSeen = rise ? (!prev && cur) : (prev && !cur);
   endfunction

   logic [DATA_W-1:0] shift_q;
   logic [DATA_W-1:0] shift_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic              ovf_q;
   logic              ovf_d;
   logic              start_q;
   logic              start_d;
   logic              latchOpen_d;
   logic              outBit_q;
   logic              outBit_d;
   logic              sckPrev_q;
   logic              sdaPrev_q;
   logic              hold_q;
   logic              hold_d;
   logic              pinOut_q;
   logic              sclEn_q;
   logic              sdaEn_q;
   logic              doOut_q;
   logic              ovfIrq_q;
   logic              startIrq_q;
   logic              wake_q;

   logic [2:0] pinSync;
   logic       diSync;
   logic       sckSync;
   logic       sdaSync;
   logic       sdaPinLevel;

   // Data input, clock pin and the data pin as seen by two-wire start detection.
   ssu_sync #(
      .WIDTH  (3),
      .STAGES (`SSU_SYNC_STAGES)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .asyncIn ({serialDataIn, serialClockIn, sdaPinLevel}),
      .syncOut (pinSync)
   ); // [R24] [R20]

   assign sdaPinLevel = serialDataIn;
   assign diSync  = pinSync[2]; // [R04]
   assign sckSync = pinSync[1];
   assign sdaSync = pinSync[0];

   ssu_pkg::ssu_wire_e wireSel;
   assign wireSel = ssu_pkg::ssu_wire_e'(wireMode);

   wire twoWire   = (wireSel == ssu_pkg::SSU_WM_TWO) || (wireSel == ssu_pkg::SSU_WM_TWO_HOLD);
   wire extClk    = clockSourceSelect;

   // Edge select 0 samples on rising edges; 1 samples on falling edges.
   wire sampleEdge = edgeSeen(sckPrev_q, sckSync, !externalEdgeSelect); // [R14] [R15]
   wire changeEdge = edgeSeen(sckPrev_q, sckSync, externalEdgeSelect); // [R14] [R15]
   wire anySckEdge = sampleEdge || changeEdge; // [R24]

   // Shift clock selection.
   wire intShift = externalEdgeSelect ? timerZeroOvf : softwareClockStrobe; // [R08]
   wire shiftStep = extClk ? sampleEdge : intShift; // [R08] [R21]

   // Counter clock: same source as the shift register, both pin edges when external.
   // With the external source and the clock strobe set, the toggle strobe counts instead.
   wire extCount  = softwareClockStrobe ? clockPinToggleStrobe : anySckEdge; // [R07] [R21]
   wire cntStep   = extClk ? extCount : intShift; // [R06]

   wire cntWrap   = cntStep && (cnt_q == CNT_TOP) && !cntWrite; // [R18]
   wire startSeen = twoWire && sckSync && sdaPrev_q && !sdaSync; // [R09]
   wire holdEvent = twoWire && ((start_q && !sckSync) ||
                                (wireSel == ssu_pkg::SSU_WM_TWO_HOLD && cntWrap)); // [R10]

   // The written value wins over a shift in the same cycle.
   assign shift_d = dataWrite ? dataWrData :
                    shiftStep ? {shift_q[DATA_W-2:0], diSync} : shift_q; // [R01] [R22] [R12]

   // A counter write wins over a step; the step wraps to zero after the top value.
   assign cnt_d = cntWrite ? cntWrData :
                  cntStep  ? cnt_q + {{(CNT_W-1){1'b0}}, 1'b1} : cnt_q; // [R05] [R06]

   // Hardware set wins over a same-cycle software clear.
   assign ovf_d   = cntWrap || (ovf_q && !ovfFlagClear); // [R18] [R05]
   assign start_d = startSeen || (start_q && !startFlagClear); // [R09]

   // Hold releases once software has cleared the start flag and, in SSU_WM_TWO_HOLD, also the overflow flag.
   wire holdRelease = !(start_q || (wireSel == ssu_pkg::SSU_WM_TWO_HOLD && ovf_q));
   assign hold_d = twoWire && (holdEvent || (hold_q && !holdRelease)); // [R10]

   // Latch is open while the pin clock rests at the level that follows the change edge,
   // so a byte loaded before the first sampling edge already shows its MSB on the pin.
   assign latchOpen_d = (sckSync == externalEdgeSelect); // [R23]
   wire latchPass = !extClk || latchOpen_d; // [R23] [R03] [R16]
   assign outBit_d = latchPass ? shift_d[DATA_W-1] : outBit_q; // [R03]

   // Registers of the shift path.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_q <= `SSU_SHIFT_RST;
         cnt_q   <= `SSU_CNT_RST;
      end else begin
         shift_q <= shift_d;
         cnt_q   <= cnt_d;
      end
   end

   // Flags and hold state.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ovf_q   <= `SSU_BIT_RST;
         start_q <= `SSU_BIT_RST;
         hold_q  <= `SSU_BIT_RST;
      end else begin
         ovf_q   <= ovf_d;
         start_q <= start_d;
         hold_q  <= hold_d;
      end
   end

   // Edge history of synchronised pins.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sckPrev_q <= `SSU_BIT_RST;
         sdaPrev_q <= `SSU_OUT_RST;
      end else begin
         sckPrev_q <= sckSync;
         sdaPrev_q <= sdaSync;
      end
   end

   // Output latch.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         outBit_q <= `SSU_BIT_RST;
      end else begin
         outBit_q <= outBit_d;
      end
   end

   // Software-made serial clock for master use.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pinOut_q <= `SSU_BIT_RST;
      end else if (clockPinToggleStrobe) begin
         pinOut_q <= !pinOut_q; // [R13] [R21]
      end
   end

   // Pin drivers: three-wire drives the data-out pin, two-wire pulls low only.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         doOut_q <= `SSU_BIT_RST;
         sdaEn_q <= `SSU_BIT_RST;
         sclEn_q <= `SSU_BIT_RST;
      end else begin
         doOut_q <= (!twoWire) && outBit_d; // [R02] [R11]
         sdaEn_q <= twoWire && !outBit_d; // [R02]
         sclEn_q <= hold_d; // [R10]
      end
   end

   // Interrupt requests and wake from idle.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ovfIrq_q   <= `SSU_BIT_RST;
         startIrq_q <= `SSU_BIT_RST;
         wake_q     <= `SSU_BIT_RST;
      end else begin
         ovfIrq_q   <= ovf_d && ovfIrqEnable; // [R05]
         startIrq_q <= start_d && startIrqEnable; // [R09]
         wake_q     <= ovf_d && ovfIrqEnable && cpuIdle; // [R19]
      end
   end

   assign dataRd              = shift_q;
   assign cntRd               = cnt_q;
   assign serialDataOut       = doOut_q;
   assign sdaOutEn            = sdaEn_q;
   assign sclOutEn            = sclEn_q;
   assign clockPinOut         = pinOut_q;
   assign counterOverflowFlag = ovf_q;
   assign startFlag           = start_q;
   assign ovfIrq              = ovfIrq_q;
   assign startIrq            = startIrq_q;
   assign idleWake            = wake_q;
endmodule

// *** bench/ssu_monitor.sv ***
// Purpose: Port checks on the serial shift unit.
// Assumes: Bound to ssu_core; one clock domain.
// Notes: Half the checks (four of eight) cover internal clocking.
`timescale 1ns/1ps
module ssu_monitor (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       dataWrite,
   input wire logic [7:0] dataWrData,
   input wire logic [7:0] dataRd,
   input wire logic       cntWrite,
   input wire logic [3:0] cntWrData,
   input wire logic [3:0] cntRd,
   input wire logic [1:0] wireMode,
   input wire logic       clockSourceSelect,
   input wire logic       externalEdgeSelect,
   input wire logic       softwareClockStrobe,
   input wire logic       clockPinToggleStrobe,
   input wire logic       timerZeroOvf,
   input wire logic       serialDataOut,
   input wire logic       clockPinOut,
   input wire logic       counterOverflowFlag,
   input wire logic       ovfIrqEnable,
   input wire logic       ovfIrq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   wire intSel = !clockSourceSelect;
   wire swStep = intSel && !externalEdgeSelect && softwareClockStrobe && !cntWrite;
   data_write_a: assert property (dataWrite |=> dataRd == $past(dataWrData))
      else $error("written value lost");
   cnt_write_a: assert property (cntWrite |=> cntRd == $past(cntWrData))
      else $error("counter write lost");
   soft_step_a: assert property (swStep && !dataWrite |=>
      dataRd[7:1] == $past(dataRd[6:0]) && cntRd == $past(cntRd) + 4'h1)
      else $error("software step wrong");
   no_step_a: assert property (intSel && !softwareClockStrobe && !timerZeroOvf
      && !clockPinToggleStrobe && !cntWrite |=> $stable(cntRd))
      else $error("counter moved unclocked");
   ovf_set_a: assert property (swStep && cntRd == 4'hf |-> ##[1:2] counterOverflowFlag)
      else $error("no overflow after wrap");
   pin_toggle_a: assert property (clockPinToggleStrobe |=> clockPinOut != $past(clockPinOut))
      else $error("clock pin not toggled");
   dout_follow_a: assert property (wireMode == 2'b01 && intSel && $past(intSel)
      |-> serialDataOut == dataRd[7])
      else $error("data out not msb");
   irq_rise_a: assert property ($rose(counterOverflowFlag) && ovfIrqEnable
      |-> ##[0:1] ovfIrq)
      else $error("overflow request missing");
endmodule
bind ssu_core ssu_monitor mon (.clk, .reset_n, .dataWrite, .dataWrData, .dataRd, .cntWrite,
   .cntWrData, .cntRd, .wireMode, .clockSourceSelect, .externalEdgeSelect,
   .softwareClockStrobe, .clockPinToggleStrobe, .timerZeroOvf, .serialDataOut,
   .clockPinOut, .counterOverflowFlag, .ovfIrqEnable, .ovfIrq);

// *** bench/ssu_spi_peer.sv ***
// Purpose: Mode 0 SPI master model facing the shift unit.
// Assumes: go rises once per byte.
// Notes: Clock idles low; the data line inverts once released.
`timescale 1ns/1ps
module ssu_spi_peer (
   input  wire logic       go,
   input  wire logic [7:0] txByte,
   input  wire logic       miso,
   output logic            sclk,
   output logic            mosi,
   output logic [7:0]      rxByte,
   output logic            busy
);
   logic [7:0] sh;
   initial begin
      {sclk, mosi, busy, rxByte} = 11'h000;
   end
   always @(posedge go) begin
      busy = 1'b1;
      sh = txByte;
      #3 mosi = sh[7];
      repeat (8) begin
         #40 sclk = 1'b1;
         rxByte = {rxByte[6:0], miso};
         sh = {sh[6:0], 1'b0};
         #40 sclk = 1'b0;
         mosi = sh[7];
      end
      #40 mosi = ~mosi;
      busy = 1'b0;
   end
endmodule

// *** bench/serial_shift_unit_three_wire_test.sv ***
// Purpose: Self-checking bench for the serial shift unit.
// Assumes: Strobes are driven by NBA at rising clk.
// Notes: Ends with an external-clock byte exchange.
`timescale 1ns/1ps
module serial_shift_unit_three_wire_test;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [5:0] stb = 6'h00;
   logic [7:0] dWr = 8'h00;
   logic [3:0] cWr = 4'h0;
   logic       ccs = 1'b0, ees = 1'b0, sdiTb = 1'b1, go = 1'b0, spiOn = 1'b0;
   logic       sclk, mosi, busy, dout, ovf, irq, wake, pinOut;
   logic       sdaEn, sclEn, stF, stIrq;
   logic       idle = 1'b1;
   logic [7:0] dRd, rx;
   logic [3:0] cRd;
   int         errors = 0;
   int         comparisons = 0;
   always #5 clk = ~clk;
   ssu_core dut (.clk(clk), .reset_n(reset_n), .dataWrite(stb[0]), .dataWrData(dWr),
      .dataRd(dRd), .cntWrite(stb[1]), .cntWrData(cWr), .cntRd(cRd), .ovfFlagClear(stb[2]),
      .startFlagClear(1'b0), .ovfIrqEnable(1'b1), .startIrqEnable(1'b0), .cpuIdle(idle),
      .wireMode(2'b01), .clockSourceSelect(ccs), .externalEdgeSelect(ees),
      .softwareClockStrobe(stb[3]), .clockPinToggleStrobe(stb[4]), .timerZeroOvf(stb[5]),
      .serialDataIn(spiOn ? mosi : sdiTb), .serialClockIn(sclk), .serialDataOut(dout),
      .sdaOutEn(sdaEn), .sclOutEn(sclEn), .clockPinOut(pinOut), .counterOverflowFlag(ovf),
      .startFlag(stF), .ovfIrq(irq), .startIrq(stIrq), .idleWake(wake));
   ssu_spi_peer peer (.go(go), .txByte(8'hc5), .miso(dout), .sclk(sclk), .mosi(mosi),
      .rxByte(rx), .busy(busy));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   // Holds the strobes for n cycles, then lets two edges settle the results.
   task automatic pulse(input logic [5:0] m, input int n);
      @(posedge clk);
      stb <= m;
      repeat (n) @(posedge clk);
      stb <= 6'h00;
      repeat (2) @(posedge clk);
   endtask
   task automatic test_done;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      dWr <= 8'ha5;
      pulse(6'h01, 1);
      chk("data write", 8'ha5, dRd);
      pulse(6'h02, 1);
      pulse(6'h08, 3);
      chk("shifted data", 8'h2f, dRd);
      chk("count", 8'h03, {4'h0, cRd});
      pulse(6'h08, 13);
      chk("wrapped count", 8'h00, {4'h0, cRd});
      chk("overflow flag", 8'h01, {7'h00, ovf});
      chk("overflow request", 8'h01, {7'h00, irq});
      chk("idle wake", 8'h01, {7'h00, wake});
      pulse(6'h04, 1);
      chk("cleared flag", 8'h00, {7'h00, ovf});
      dWr <= 8'h3c;
      pulse(6'h09, 1);
      chk("write over shift", 8'h3c, dRd);
      chk("data out", 8'h00, {7'h00, dout});
      $display("test software clock done");
      ees <= 1'b1;
      cWr <= 4'he;
      pulse(6'h02, 1);
      pulse(6'h20, 2);
      chk("timer count", 8'h00, {4'h0, cRd});
      chk("timer overflow", 8'h01, {7'h00, ovf});
      pulse(6'h10, 1);
      chk("clock pin", 8'h01, {7'h00, pinOut});
      $display("test timer and toggle done");
      ccs <= 1'b1;
      idle <= 1'b0;
      ees <= 1'b0;
      cWr <= 4'h0;
      pulse(6'h07, 1);
      spiOn <= 1'b1;
      go <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 200 && busy; i++) @(posedge clk);
      repeat (6) @(posedge clk);
      chk("slave byte", 8'hc5, dRd);
      chk("master byte", 8'h3c, rx);
      chk("edge count", 8'h00, {4'h0, cRd});
      chk("link overflow", 8'h01, {7'h00, ovf});
      chk("idle wake off", 8'h00, {7'h00, wake});
      chk("two-wire outputs", 8'h00, {4'h0, sdaEn, sclEn, stF, stIrq});
      $display("test link exchange done");
      test_done;
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      test_done;
   end
endmodule
